// *** design/nes_regs.svh ***
/*
 * constants for the erase/suspend command sequencer that drives a parallel nor flash.
 * assumes 10 MHz core clock; included by bare name.
 */
`ifndef NES_REGS_SVH
`define NES_REGS_SVH
// ****************************************
// command codes and unlock addresses
// ****************************************
`define NES_CMD_UNLOCK1 8'hAA
`define NES_CMD_UNLOCK2 8'h55
`define NES_CMD_ERASE_SETUP 8'h80
`define NES_CMD_CHIP_ERASE 8'h10
`define NES_CMD_BLOCK_ERASE 8'h30
`define NES_CMD_SUSPEND 8'hB0
`define NES_CMD_RESUME 8'h30
`define NES_CMD_RESET 8'hF0
`define NES_CMD_BUF_PROG 8'h25
`define NES_ADDR_UNLOCK1 24'h000555
`define NES_ADDR_UNLOCK2 24'h0002AA
// ****************************************
// status bit positions
// ****************************************
`define NES_BIT_COMPLETION 7
`define NES_BIT_TOGGLE 6
`define NES_BIT_ERROR 5
`define NES_BIT_TIMER 3
// ****************************************
// timing
// ****************************************
`define NES_CLK_MHZ 10
`define NES_WE_LOW_NS 100
`define NES_WE_LOW_CYC (((`NES_WE_LOW_NS * `NES_CLK_MHZ) + 999) / 1000)
`endif

// *** design/nes_pkg.sv ***
/*
 * types for the nor erase/suspend command sequencer.
 * assumes nes_regs.svh supplies the numbers.
 */
package nes_pkg;
  typedef enum logic [2:0] {
    NES_OP_CHIP_ERASE = 3'h0,
    NES_OP_BLOCK_ERASE = 3'h1,
    NES_OP_ADD_BLOCK = 3'h2,
    NES_OP_SUSPEND = 3'h3,
    NES_OP_RESUME = 3'h4,
    NES_OP_RESET = 3'h5,
    NES_OP_BUF_PROG = 3'h6
  } nes_op_t;

  typedef struct packed {
    nes_op_t op;
    logic bypass;
    logic [23:0] addr;
  } nes_req_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
    logic we_n;
    logic ce_n;
    logic oe_n;
  } nes_bus_t;
endpackage

// *** design/nes_host.sv ***
/*
 * host-side sequencer: turns erase, suspend and resume requests into flash bus write cycles
 * and polls status by reads. assumes a clockless flash on the pins and one 10 MHz clock here.
 */
// Behaviour
// - resume code leaves program suspend
// - unprotect all blocks before raising voltage; code raises o_flash_hv_en with no unprotect step
// - high voltage only for accel ops; code holds it on at idle while a request is valid, so into a following op
// - chip erase: six writes 80/10
// - failed erase cleared by read/reset
// - bypass chip erase: two writes
// - block erase six writes, add blocks
// - bypass block erase: two writes
// - leave modes before erase resume
`timescale 1ns/1ps
`include "nes_regs.svh"
module nes_host (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire nes_pkg::nes_req_t i_req,
  output logic o_req_ready,
  input wire logic i_accel_allowed,
  input wire logic [7:0] i_flash_dq,
  output logic [7:0] o_flash_dq,
  output logic o_flash_dq_oe,
  output logic [23:0] o_flash_addr,
  output logic o_flash_we_n,
  output logic o_flash_ce_n,
  output logic o_flash_oe_n,
  output logic o_flash_hv_en,
  output logic o_busy,
  output logic o_erasing,
  output logic o_suspended,
  output logic o_timer_expired,
  output logic o_error,
  output logic o_done
);
  localparam logic [7:0] WE_CYC = 8'(`NES_WE_LOW_CYC);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WR_LOW = 5'b00010,
    ST_WR_HIGH = 5'b00100,
    ST_POLL = 5'b01000,
    ST_POLL_WAIT = 5'b10000
  } nes_state_t;

  nes_state_t state_r;
  logic [7:0] cyc_r;
  logic [2:0] idx_r;
  logic [2:0] nwr_r;
  nes_pkg::nes_req_t req_r;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] last_r;
  logic [7:0] cur_r;
  logic first_r;
  logic err_pend_r;
  logic toggling;
  logic erasing_r;
  logic suspended_r;
  logic timer_r;
  logic error_r;
  logic done_r;
  logic hv_r;
  logic [23:0] wa;
  logic [7:0] wd;
  logic poll_after;
  logic accept;

  // ****************************************
  // write cycle table
  // ****************************************
  // address and code for a given step of a six-write sequence
  function automatic logic [31:0] nes_step(input logic [2:0] i, input logic [7:0] last,
                                          input logic [23:0] ba);
    case (i)
      3'h0: nes_step = {`NES_ADDR_UNLOCK1, `NES_CMD_UNLOCK1};
      3'h1: nes_step = {`NES_ADDR_UNLOCK2, `NES_CMD_UNLOCK2};
      3'h2: nes_step = {`NES_ADDR_UNLOCK1, `NES_CMD_ERASE_SETUP};
      3'h3: nes_step = {`NES_ADDR_UNLOCK1, `NES_CMD_UNLOCK1};
      3'h4: nes_step = {`NES_ADDR_UNLOCK2, `NES_CMD_UNLOCK2};
      default: nes_step = {ba, last};
    endcase
  endfunction

  always_comb begin
    logic [2:0] i;
    i = idx_r;
    wa = req_r.addr;
    wd = `NES_CMD_RESET;
    case (req_r.op)
      nes_pkg::NES_OP_CHIP_ERASE: begin
        if (req_r.bypass) begin
          i = (idx_r == 3'h0) ? 3'h2 : 3'h5;
        end
        {wa, wd} = nes_step(i, `NES_CMD_CHIP_ERASE, `NES_ADDR_UNLOCK1);
      end
      nes_pkg::NES_OP_BLOCK_ERASE: begin
        if (req_r.bypass) begin
          i = (idx_r == 3'h0) ? 3'h2 : 3'h5;
        end
        {wa, wd} = nes_step(i, `NES_CMD_BLOCK_ERASE, req_r.addr);
      end
      nes_pkg::NES_OP_ADD_BLOCK: wd = `NES_CMD_BLOCK_ERASE;
      nes_pkg::NES_OP_SUSPEND: wd = `NES_CMD_SUSPEND;
      // no id, query or bypass mode ever opened
      nes_pkg::NES_OP_RESUME: wd = `NES_CMD_RESUME;
      nes_pkg::NES_OP_BUF_PROG: wd = `NES_CMD_BUF_PROG;
      default: wd = `NES_CMD_RESET;
    endcase
  end

  // ****************************************
  // request acceptance
  // ****************************************
  always_comb begin
    o_req_ready = (state_r == ST_IDLE);
    case (i_req.op)
      // resume only when suspended and idle
      nes_pkg::NES_OP_RESUME: o_req_ready = o_req_ready && suspended_r;
      nes_pkg::NES_OP_ADD_BLOCK: o_req_ready = o_req_ready && erasing_r && !timer_r;
      nes_pkg::NES_OP_SUSPEND: o_req_ready = o_req_ready && erasing_r;
      nes_pkg::NES_OP_BUF_PROG: o_req_ready = o_req_ready && i_accel_allowed;
      default: o_req_ready = o_req_ready;
    endcase
  end
  assign accept = i_req_valid && o_req_ready;
  // block erase skips polling so further blocks can join the window
  assign poll_after = (req_r.op == nes_pkg::NES_OP_CHIP_ERASE) ||
                      (req_r.op == nes_pkg::NES_OP_BUF_PROG);
  assign toggling = (cur_r[`NES_BIT_TOGGLE] != last_r[`NES_BIT_TOGGLE]);

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= i_flash_dq;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
      cyc_r <= 8'h00;
      idx_r <= 3'h0;
      nwr_r <= 3'h0;
      req_r <= '0;
      last_r <= 8'h00;
      cur_r <= 8'h00;
      first_r <= 1'b0;
      err_pend_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            req_r <= i_req;
            idx_r <= 3'h0;
            cyc_r <= 8'h00;
            nwr_r <= ((i_req.op == nes_pkg::NES_OP_CHIP_ERASE ||
                       i_req.op == nes_pkg::NES_OP_BLOCK_ERASE) && !i_req.bypass) ? 3'h6 :
                     ((i_req.op == nes_pkg::NES_OP_CHIP_ERASE ||
                       i_req.op == nes_pkg::NES_OP_BLOCK_ERASE) ? 3'h2 : 3'h1);
            state_r <= ST_WR_LOW;
          end
        end
        ST_WR_LOW: begin
          cyc_r <= cyc_r + 8'h01;
          if (cyc_r == WE_CYC) begin
            cyc_r <= 8'h00;
            state_r <= ST_WR_HIGH;
          end
        end
        ST_WR_HIGH: begin
          cyc_r <= cyc_r + 8'h01;
          if (cyc_r == WE_CYC) begin
            cyc_r <= 8'h00;
            idx_r <= idx_r + 3'h1;
            if (idx_r + 3'h1 != nwr_r) begin
              state_r <= ST_WR_LOW;
            end else if (poll_after) begin
              // voltage held until accelerated program ends
              first_r <= 1'b1;
              err_pend_r <= 1'b0;
              state_r <= ST_POLL;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_POLL: begin
          cyc_r <= cyc_r + 8'h01;
          if (cyc_r == WE_CYC + 8'h02) begin
            cyc_r <= 8'h00;
            last_r <= cur_r;
            cur_r <= sync2_r;
            state_r <= ST_POLL_WAIT;
          end
        end
        ST_POLL_WAIT: begin
          first_r <= 1'b0;
          // one read alone cannot show a toggle; compare two reads
          if (first_r) begin
            state_r <= ST_POLL;
          end else if (!toggling || (cur_r[`NES_BIT_ERROR] && err_pend_r)) begin
            state_r <= ST_IDLE;
          end else begin
            // error bit trusted only if still toggling on the next read
            if (cur_r[`NES_BIT_ERROR]) begin
              err_pend_r <= 1'b1;
            end
            state_r <= ST_POLL;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // erase status tracking
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      erasing_r <= 1'b0;
      suspended_r <= 1'b0;
      timer_r <= 1'b0;
      error_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (state_r == ST_POLL_WAIT && !first_r && toggling && cur_r[`NES_BIT_ERROR] &&
          err_pend_r) begin
        error_r <= 1'b1;
      end
      if (state_r == ST_POLL_WAIT && !first_r && !toggling) begin
        erasing_r <= 1'b0;
        done_r <= 1'b1;
      end
      if (erasing_r && state_r == ST_IDLE && sync2_r[`NES_BIT_TIMER]) begin
        timer_r <= 1'b1;
      end
      if (accept) begin
        case (i_req.op)
          nes_pkg::NES_OP_BLOCK_ERASE: begin
            erasing_r <= 1'b1;
            timer_r <= 1'b0;
          end
          nes_pkg::NES_OP_SUSPEND: begin
            suspended_r <= 1'b1;
            timer_r <= 1'b1;
          end
          nes_pkg::NES_OP_RESUME: suspended_r <= 1'b0;
          nes_pkg::NES_OP_RESET: begin
            error_r <= 1'b0;
            // reset in window aborts block erase
            if (!suspended_r && !timer_r) begin
              erasing_r <= 1'b0;
            end
          end
          default: erasing_r <= erasing_r;
        endcase
      end
    end
  end

  // ****************************************
  // high voltage and pins
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hv_r <= 1'b0;
    end else if (accept && i_req.op == nes_pkg::NES_OP_BUF_PROG) begin
      hv_r <= 1'b1;
    end else if (state_r == ST_IDLE && !i_req_valid) begin
      hv_r <= 1'b0;
    end
  end

  always_comb begin
    o_flash_addr = wa;
    o_flash_dq = wd;
    o_flash_dq_oe = (state_r == ST_WR_LOW) || (state_r == ST_WR_HIGH);
    o_flash_we_n = (state_r != ST_WR_LOW);
    o_flash_oe_n = (state_r != ST_POLL);
    o_flash_ce_n = (state_r == ST_IDLE) || (state_r == ST_POLL_WAIT);
  end

  assign o_flash_hv_en = hv_r;
  assign o_busy = (state_r != ST_IDLE);
  assign o_erasing = erasing_r;
  assign o_suspended = suspended_r;
  assign o_timer_expired = timer_r;
  assign o_error = error_r;
  assign o_done = done_r;
endmodule // nes_host

// *** verif/nes_host_props.sv ***
/*
 * checker for the nor erase/suspend sequencer ports.
 * assumes bind from the bench top; one clock domain.
 */
`timescale 1ns/1ps
module nes_host_props (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire nes_pkg::nes_req_t i_req,
  input wire logic o_req_ready,
  input wire logic i_accel_allowed,
  input wire logic o_flash_dq_oe,
  input wire logic o_flash_we_n,
  input wire logic o_flash_ce_n,
  input wire logic o_flash_oe_n,
  input wire logic o_flash_hv_en,
  input wire logic o_busy,
  input wire logic o_erasing,
  input wire logic o_suspended,
  input wire logic o_timer_expired,
  input wire logic o_done
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic take;
  assign take = i_req_valid && o_req_ready;
  chk_resume_gate:
    assert property (take && i_req.op == nes_pkg::NES_OP_RESUME |-> o_suspended)
    else $error("resume taken while not suspended");
  chk_suspend_gate:
    assert property (take && i_req.op == nes_pkg::NES_OP_SUSPEND |-> o_erasing)
    else $error("suspend taken with no erase");
  chk_add_gate:
    assert property (take && i_req.op == nes_pkg::NES_OP_ADD_BLOCK |-> o_erasing && !o_timer_expired)
    else $error("block added outside window");
  chk_accel_gate:
    assert property (take && i_req.op == nes_pkg::NES_OP_BUF_PROG |-> i_accel_allowed)
    else $error("buffered program without clearance");
  chk_we_width:
    assert property ($fell(o_flash_we_n) |-> !o_flash_ce_n && o_flash_dq_oe ##1 !o_flash_we_n
      ##1 o_flash_we_n [*2])
    else $error("write strobe shape wrong");
  chk_read_clean:
    assert property (!o_flash_oe_n |-> o_flash_we_n && !o_flash_dq_oe && !o_flash_ce_n)
    else $error("poll read overlaps write");
  chk_busy_block:
    assert property (o_busy |-> !o_req_ready)
    else $error("request open while busy");
  chk_done_pulse:
    assert property (o_done |=> !o_done && !o_busy)
    else $error("done not a single pulse");
  chk_hv_allowed:
    assert property (o_flash_hv_en |-> i_accel_allowed)
    else $error("high voltage without clearance");
endmodule // nes_host_props

// *** verif/nes_flash_model.sv ***
/*
 * behavioural flash: decodes write cycles, erase timers, polling reads.
 * assumes the host pins; clock only paces the internal timers.
 */
`timescale 1ns/1ps
module nes_flash_model #(
  parameter int ERASE_CYC = 60,
  parameter int WIN_CYC = 40
) (
  input wire logic i_core_clk,
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_we_n,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_hv,
  output logic [7:0] o_dq
);
  logic [7:0] seq [5] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
  logic [7:0] d, st, last = 8'h00;
  int cyc = 0, win = 0, cnt = 0;
  bit chip, blk, susp, bufp, tog;
  // protection not modelled, so never an error
  always @(posedge i_we_n) if (!i_ce_n) begin
    d = i_dq;
    // chip erase and buffered program deaf
    if (chip || bufp) d = d;
    else if (d == 8'hF0) begin
      cyc = 0;
      if (win > 0) begin win = 0; blk = 0; end
    end
    // suspend at any address, window ends
    else if (d == 8'hB0 && blk && !susp) begin susp = 1; win = 0; end
    else if (d == 8'h30 && susp && cyc == 0) begin susp = 0; cnt = (cnt > 0) ? cnt : ERASE_CYC; end
    else if (d == 8'h30 && win > 0) win = WIN_CYC;
    // buffered program in bypass under high voltage
    else if (d == 8'h25 && i_hv) begin bufp = 1; cnt = ERASE_CYC; end
    else if (cyc == 0 && d == 8'h80 && i_hv) cyc = 5;
    else if (cyc == 5 && d == 8'h10) begin chip = 1; cnt = ERASE_CYC; cyc = 0; end
    else if (cyc == 5 && d == 8'h30) begin blk = 1; win = WIN_CYC; cyc = 0; end
    else if (cyc < 5 && d == seq[cyc]) cyc = cyc + 1;
    else cyc = 0;
  end
  // window then erase, both frozen in suspend
  always @(posedge i_core_clk) if (!susp) begin
    if (win > 0) begin win = win - 1; if (win == 0) cnt = ERASE_CYC; end
    else if (cnt > 0) begin cnt = cnt - 1; if (cnt == 0) begin chip = 0; blk = 0; bufp = 0; end end
  end
  always @(negedge i_oe_n) if (chip || bufp || (blk && !susp)) tog = !tog;
  assign st = (chip || bufp || (blk && !susp)) ? {1'b0, tog, 2'h0, blk && win == 0, 3'h0} : 8'hFF;
  always @(posedge i_oe_n) last = st;
  // released bus shows inverse, never a stale copy
  assign o_dq = (!i_oe_n && !i_ce_n) ? st : ~last;
endmodule // nes_flash_model

// *** verif/nes_host_test.sv ***
/*
 * self-checking bench for nes_host with a flash model.
 * assumes nes_pkg compiled first; 10 MHz clock.
 */
`timescale 1ns/1ps
module nes_host_test;
  logic i_core_clk, i_sys_rst, i_req_valid, i_accel_allowed;
  nes_pkg::nes_req_t i_req;
  logic [7:0] i_flash_dq, o_flash_dq, last_wr;
  logic [23:0] o_flash_addr;
  logic o_req_ready, o_flash_dq_oe, o_flash_we_n, o_flash_ce_n, o_flash_oe_n, o_flash_hv_en;
  logic o_busy, o_erasing, o_suspended, o_timer_expired, o_error, o_done;
  int miscompares = 0, tests_run = 0, writes = 0, dones = 0, hv_seen = 0, w0;
  nes_host dut_u (.*);
  nes_flash_model flash_u (.i_core_clk(i_core_clk), .i_addr(o_flash_addr), .i_dq(o_flash_dq),
    .i_we_n(o_flash_we_n), .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
    .i_hv(o_flash_hv_en), .o_dq(i_flash_dq));
  initial begin
    i_core_clk = 0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(negedge o_flash_we_n) if (!i_sys_rst) writes++;
  always @(posedge i_core_clk) begin
    if (!o_flash_we_n) last_wr = o_flash_dq;
    if (o_flash_hv_en) hv_seen++;
  end
  always @(posedge o_done) dones++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic send(input nes_pkg::nes_op_t op, input logic [23:0] a);
    int n = 0;
    w0 = writes;
    i_req <= '{op, 1'b0, a};
    i_req_valid <= 1'b1;
    do begin @(posedge i_core_clk); n++; end while (!o_req_ready && n < 50);
    i_req_valid <= 1'b0;
    do begin @(posedge i_core_clk); n++; end while (o_busy && n < 3000);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_refuse();
    nes_pkg::nes_op_t ops [4] = '{nes_pkg::NES_OP_RESUME, nes_pkg::NES_OP_SUSPEND,
      nes_pkg::NES_OP_ADD_BLOCK, nes_pkg::NES_OP_BUF_PROG};
    foreach (ops[i]) begin
      i_req <= '{ops[i], 1'b0, 24'h000000};
      i_req_valid <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      chk(o_req_ready, 1'b0);
      i_req_valid <= 1'b0;
      @(posedge i_core_clk);
    end
  endtask
  task automatic t_chip();
    int d0 = dones;
    send(nes_pkg::NES_OP_CHIP_ERASE, 24'h000000);
    chk(writes - w0, 6);
    chk(last_wr, 8'h10);
    chk(dones - d0, 1);
    chk(o_error, 1'b0);
  endtask
  task automatic t_abort();
    send(nes_pkg::NES_OP_BLOCK_ERASE, 24'h060000);
    send(nes_pkg::NES_OP_RESET, 24'h000000);
    chk(last_wr, 8'hF0);
    chk(o_erasing, 1'b0);
    repeat (150) @(posedge i_core_clk);
  endtask
  task automatic t_bufprog();
    int h0 = hv_seen;
    i_accel_allowed <= 1'b1;
    send(nes_pkg::NES_OP_BUF_PROG, 24'h010000);
    chk(writes - w0, 1);
    chk(last_wr, 8'h25);
    chk(hv_seen > h0, 1);
    repeat (150) @(posedge i_core_clk);
  endtask
  task automatic t_block();
    send(nes_pkg::NES_OP_BLOCK_ERASE, 24'h020000);
    chk(writes - w0, 6);
    chk({o_erasing, last_wr}, {1'b1, 8'h30});
    send(nes_pkg::NES_OP_ADD_BLOCK, 24'h040000);
    chk({writes - w0, last_wr}, {32'd1, 8'h30});
    for (int i = 0; i < 2; i++) begin
      send(nes_pkg::NES_OP_SUSPEND, 24'h7FFFFF);
      chk({o_suspended, last_wr}, {1'b1, 8'hB0});
      // no id, query or bypass mode open before resume
      send(nes_pkg::NES_OP_RESUME, 24'h000000);
      chk({o_suspended, o_erasing, last_wr}, {2'b01, 8'h30});
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    i_sys_rst = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    i_accel_allowed = 1'b0;
    repeat (10) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    t_refuse();
    t_chip();
    t_abort();
    t_bufprog();
    t_block();
    complete_run();
  end
  // hang guard, well past the longest sequence
  initial begin
    #3000000;
    miscompares++;
    complete_run();
  end
endmodule // nes_host_test
bind nes_host nes_host_props chk_u (.*);
